/* logic/cds_defines.svh */
`ifndef CDS_DEFINES_SVH
`define CDS_DEFINES_SVH
`define CDS_OFF_GAIN_TRIM 8'h44
`define CDS_OFF_PHASE_TRIM 8'h45
`define CDS_OFF_SCAN_SEL 8'h64
`define CDS_OFF_THRESH_A 8'h65
`define CDS_RST_GAIN_TRIM 4'h8
`define CDS_RST_PHASE_TRIM 8'h00
`define CDS_RST_SCAN_SEL 8'h00
`define CDS_RST_THRESH_A 8'h37
`define CDS_POS_GAIN_TRIM 4
`define CDS_POS_CH_A_SCAN 7
`define CDS_POS_CH_B_SCAN 6
`define CDS_POS_SE_NEG 1
`define CDS_POS_AC_PINS 0
`define CDS_INSRC_DIFF 2'h0
`define CDS_INSRC_SE 2'h1
`define CDS_COUP_AC 1'h0
`endif

/* logic/cds_pkg.sv */
package cds_pkg;
    typedef logic [7:0] cds_byte_t;
    typedef enum logic [1:0] {
        CDS_PIN_A_POS,
        CDS_PIN_A_NEG,
        CDS_PIN_B_POS,
        CDS_PIN_B_NEG
    } cds_pin_e;
endpackage

/* logic/cds_phase_delay.sv */
`include "cds_defines.svh"
module cds_phase_delay
    import cds_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 256
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mod_tick,
    input wire logic [7:0] delay,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] line_ff [DEPTH];
    logic [7:0] wr_ptr_ff;
    logic [7:0] rd_idx;

    ////////////////////////////////////////////////////////////////////////
    // Circular line; a tick reads the sample taken delay ticks earlier
    assign rd_idx = 8'(wr_ptr_ff - delay);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= 8'h00;
        end else if (mod_tick) begin
            wr_ptr_ff <= 8'(wr_ptr_ff + 8'h01);
        end
    end

    always_ff @(posedge clk) begin
        if (mod_tick) begin
            line_ff[wr_ptr_ff] <= din;
        end
    end

    // Zero delay bypasses the line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout <= '0;
        end else if (mod_tick) begin
            dout <= (delay == 8'h00) ? din : line_ff[rd_idx];
        end
    end
endmodule

/* logic/cds_cal_scan_cfg.sv */
`include "cds_defines.svh"
// Notes on behaviour
// - Gain trim bits 7:4, -0.8 to +0.7 dB
// - Gain trim resets to code 8, 0 dB
// - Gain register low nibble reads zero
// - Channel B delayed by phase trim cycles
// - Phase trim zero adds no delay
// - Bit 7 enables channel A pin scan
// - Bit 6 enables channel B pin scan
// - Bit 1 includes single-ended negative pins
// - Bit 0 includes AC-coupled channel pins
// - Input config 0 differential, 1 single-ended
// - Coupling bit 0 AC, 1 DC
module cds_cal_scan_cfg
    import cds_pkg::*;
#(
    parameter int SAMPLE_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] ch_a_input_config,
    input wire logic ch_a_coupling,
    input wire logic [1:0] ch_b_input_config,
    input wire logic ch_b_coupling,
    input wire logic scan_step,
    input wire logic mod_tick,
    input wire logic [SAMPLE_W-1:0] ch_b_sample_in,
    output logic [SAMPLE_W-1:0] ch_b_sample_out,
    output logic [3:0] ch_b_gain_trim,
    output logic signed [4:0] ch_b_gain_trim_tenth_db,
    output logic [3:0] scan_pin_mask,
    output logic scan_pin_valid,
    output logic [1:0] scan_pin,
    output logic [7:0] diag_threshold_reg_a
);
    logic [3:0] gain_ff;
    logic [7:0] phase_ff;
    logic [7:0] scan_sel_ff;
    logic [7:0] thresh_ff;
    logic [3:0] nxt_mask;
    logic [1:0] cur_ff;
    logic [7:0] rdata_ff;
    logic [3:0] mask_ff;
    logic valid_ff;
    logic [1:0] pin_ff;
    logic signed [4:0] tenth_ff;
    logic ch_a_se;
    logic ch_b_se;
    logic ch_a_ac;
    logic ch_b_ac;
    logic [3:0] reg_hit;
    logic [SAMPLE_W-1:0] last_in_ff;
    logic last_ok_ff;

    ////////////////////////////////////////////////////////////////////////
    // Address decode, shared by writes and reads
    function automatic logic [3:0] reg_decode(input logic [7:0] addr);
        reg_decode = 4'h0;
        if (addr == `CDS_OFF_GAIN_TRIM) begin
            reg_decode = 4'h1;
        end else if (addr == `CDS_OFF_PHASE_TRIM) begin
            reg_decode = 4'h2;
        end else if (addr == `CDS_OFF_SCAN_SEL) begin
            reg_decode = 4'h4;
        end else if (addr == `CDS_OFF_THRESH_A) begin
            reg_decode = 4'h8;
        end
    endfunction

    assign reg_hit = reg_decode(reg_addr);

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gain_ff <= `CDS_RST_GAIN_TRIM;
            phase_ff <= `CDS_RST_PHASE_TRIM;
            scan_sel_ff <= `CDS_RST_SCAN_SEL;
            thresh_ff <= `CDS_RST_THRESH_A;
        end else if (reg_wr) begin
            if (reg_hit[0]) begin
                gain_ff <= reg_wdata[`CDS_POS_GAIN_TRIM +: 4];
            end else if (reg_hit[1]) begin
                phase_ff <= reg_wdata;
            end else if (reg_hit[2]) begin
                scan_sel_ff <= reg_wdata;
            end else if (reg_hit[3]) begin
                thresh_ff <= reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads, registered one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            if (reg_hit[0]) begin
                rdata_ff <= {gain_ff, 4'h0};
            end else if (reg_hit[1]) begin
                rdata_ff <= phase_ff;
            end else if (reg_hit[2]) begin
                rdata_ff <= scan_sel_ff;
            end else if (reg_hit[3]) begin
                rdata_ff <= thresh_ff;
            end else begin
                rdata_ff <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gain trim outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tenth_ff <= 5'sh00;
        end else begin
            tenth_ff <= $signed({1'b0, gain_ff}) - 5'sh08;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scan pin filter
    assign ch_a_se = (ch_a_input_config == `CDS_INSRC_SE);
    assign ch_b_se = (ch_b_input_config == `CDS_INSRC_SE);
    assign ch_a_ac = (ch_a_coupling == `CDS_COUP_AC);
    assign ch_b_ac = (ch_b_coupling == `CDS_COUP_AC);

    function automatic logic [1:0] chan_pins(input logic en, input logic se, input logic ac,
                                              input logic incl_se, input logic incl_ac);
        logic ok;
        ok = en && (!ac || incl_ac);
        chan_pins = {ok && (!se || incl_se), ok};
    endfunction

    always_comb begin
        nxt_mask[1:0] = chan_pins(scan_sel_ff[`CDS_POS_CH_A_SCAN], ch_a_se, ch_a_ac,
                                  scan_sel_ff[`CDS_POS_SE_NEG], scan_sel_ff[`CDS_POS_AC_PINS]);
        nxt_mask[3:2] = chan_pins(scan_sel_ff[`CDS_POS_CH_B_SCAN], ch_b_se, ch_b_ac,
                                  scan_sel_ff[`CDS_POS_SE_NEG], scan_sel_ff[`CDS_POS_AC_PINS]);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_ff <= 4'h0;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scan sequencer: advance to next enabled pin on each step
    function automatic logic [2:0] next_pin(input logic [1:0] cur, input logic [3:0] m);
        logic [1:0] p;
        next_pin = 3'h0;
        for (int i = 1; i <= 4; i++) begin
            p = 2'(cur + 2'(i));
            if (m[p] && !next_pin[2]) begin
                next_pin = {1'b1, p};
            end
        end
    endfunction

    logic [2:0] nxt_pin;
    assign nxt_pin = next_pin(cur_ff, mask_ff);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= 2'h3;
            valid_ff <= 1'b0;
            pin_ff <= 2'h0;
        end else if (scan_step) begin
            valid_ff <= nxt_pin[2];
            if (nxt_pin[2]) begin
                cur_ff <= nxt_pin[1:0];
                pin_ff <= nxt_pin[1:0];
            end
        end else begin
            valid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel B phase delay line
    cds_phase_delay #(
        .WIDTH(SAMPLE_W),
        .DEPTH(256)
    ) u_delay (
        .clk(clk),
        .rst_n(rst_n),
        .mod_tick(mod_tick),
        .delay(phase_ff),
        .din(ch_b_sample_in),
        .dout(ch_b_sample_out)
    );

    // Last sample taken on a tick, kept for the one-cycle delay check
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_in_ff <= '0;
            last_ok_ff <= 1'b0;
        end else if (mod_tick) begin
            last_in_ff <= ch_b_sample_in;
            last_ok_ff <= 1'b1;
        end
    end

    assign reg_rdata = rdata_ff;
    assign ch_b_gain_trim = gain_ff;
    assign ch_b_gain_trim_tenth_db = tenth_ff;
    assign scan_pin_mask = mask_ff;
    assign scan_pin_valid = valid_ff;
    assign scan_pin = pin_ff;
    assign diag_threshold_reg_a = thresh_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_gain_reset: assert property (@(posedge clk) $rose(rst_n) |-> gain_ff == 4'h8)
        else $error("gain trim not at 0 dB after reset");
    a_gain_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
        $past(reg_rd) && $past(reg_addr) == 8'h44 |-> reg_rdata[3:0] == 4'h0)
        else $error("gain low nibble not zero");
    a_gain_db_map: assert property (@(posedge clk) disable iff (!rst_n)
        $stable(gain_ff) |-> 5'(tenth_ff + 5'sd8) == {1'b0, gain_ff})
        else $error("gain trim decibel mapping wrong");
    a_ch_a_off: assert property (@(posedge clk) disable iff (!rst_n)
        !scan_sel_ff[7] |=> mask_ff[1:0] == 2'h0)
        else $error("channel A scanned while disabled");
    a_ch_b_off: assert property (@(posedge clk) disable iff (!rst_n)
        !scan_sel_ff[6] |=> mask_ff[3:2] == 2'h0)
        else $error("channel B scanned while disabled");
    a_se_neg_skip: assert property (@(posedge clk) disable iff (!rst_n)
        !scan_sel_ff[1] && ch_a_input_config == 2'h1 |=> !mask_ff[1])
        else $error("single-ended negative pin scanned");
    a_ac_excluded: assert property (@(posedge clk) disable iff (!rst_n)
        !scan_sel_ff[0] && !ch_b_coupling |=> mask_ff[3:2] == 2'h0)
        else $error("AC-coupled pins scanned");
    a_visit_enabled: assert property (@(posedge clk) disable iff (!rst_n)
        valid_ff |-> ($past(mask_ff) & (4'h1 << pin_ff)) != 4'h0)
        else $error("scan visited disabled pin");
    a_visit_mask: assert property (@(posedge clk) disable iff (!rst_n)
        scan_step && mask_ff == 4'h0 |=> !valid_ff)
        else $error("scan result with no enabled pin");
    a_zero_delay: assert property (@(posedge clk) disable iff (!rst_n)
        mod_tick && phase_ff == 8'h00 |=> ch_b_sample_out == $past(ch_b_sample_in))
        else $error("zero phase trim added delay");
    a_one_delay: assert property (@(posedge clk) disable iff (!rst_n)
        mod_tick && last_ok_ff && phase_ff == 8'h01 |=> ch_b_sample_out == $past(last_in_ff))
        else $error("one cycle phase trim wrong");
    a_phase_write: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == `CDS_OFF_PHASE_TRIM |=> phase_ff == $past(reg_wdata))
        else $error("phase trim write lost");
    a_phase_read: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == `CDS_OFF_PHASE_TRIM |=> reg_rdata == $past(phase_ff))
        else $error("phase trim read wrong");
    a_gain_write: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == `CDS_OFF_GAIN_TRIM |=> ch_b_gain_trim == $past(reg_wdata[`CDS_POS_GAIN_TRIM +: 4]))
        else $error("gain trim write lost");
    a_gain_read: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == `CDS_OFF_GAIN_TRIM |=> reg_rdata[7:4] == $past(gain_ff))
        else $error("gain trim read wrong");
    a_tenth_zero: assert property (@(posedge clk) disable iff (!rst_n)
        $stable(gain_ff) && gain_ff == `CDS_RST_GAIN_TRIM |-> tenth_ff == 5'sd0)
        else $error("code 8 not 0 dB");
    a_scan_write: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == `CDS_OFF_SCAN_SEL |=> scan_sel_ff == $past(reg_wdata))
        else $error("scan select write lost");
    a_ch_a_on: assert property (@(posedge clk) disable iff (!rst_n)
        scan_sel_ff[`CDS_POS_CH_A_SCAN] && ch_a_coupling != `CDS_COUP_AC |=> mask_ff[0])
        else $error("enabled channel A not scanned");
    a_ch_b_on: assert property (@(posedge clk) disable iff (!rst_n)
        scan_sel_ff[`CDS_POS_CH_B_SCAN] && ch_b_coupling != `CDS_COUP_AC |=> mask_ff[2])
        else $error("enabled channel B not scanned");
    a_se_neg_b: assert property (@(posedge clk) disable iff (!rst_n)
        !scan_sel_ff[`CDS_POS_SE_NEG] && ch_b_input_config == `CDS_INSRC_SE |=> !mask_ff[3])
        else $error("single-ended negative pin of B scanned");
    a_se_neg_incl: assert property (@(posedge clk) disable iff (!rst_n)
        scan_sel_ff[`CDS_POS_SE_NEG] && scan_sel_ff[`CDS_POS_CH_A_SCAN] && ch_a_coupling != `CDS_COUP_AC
        |=> mask_ff[1])
        else $error("included negative pin skipped");
    a_ac_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
        !scan_sel_ff[`CDS_POS_AC_PINS] && ch_a_coupling == `CDS_COUP_AC |=> mask_ff[1:0] == 2'h0)
        else $error("AC-coupled channel A scanned");
    a_ac_incl_b: assert property (@(posedge clk) disable iff (!rst_n)
        scan_sel_ff[`CDS_POS_AC_PINS] && scan_sel_ff[`CDS_POS_CH_B_SCAN] |=> mask_ff[2])
        else $error("included AC-coupled pin skipped");
    a_diff_neg: assert property (@(posedge clk) disable iff (!rst_n)
        scan_sel_ff[`CDS_POS_CH_A_SCAN] && ch_a_coupling != `CDS_COUP_AC && ch_a_input_config == `CDS_INSRC_DIFF
        |=> mask_ff[1])
        else $error("differential negative pin skipped");
    a_se_pos_only: assert property (@(posedge clk) disable iff (!rst_n)
        scan_sel_ff[`CDS_POS_CH_A_SCAN] && ch_a_coupling != `CDS_COUP_AC && ch_a_input_config == `CDS_INSRC_SE
        && !scan_sel_ff[`CDS_POS_SE_NEG] |=> mask_ff[1:0] == 2'h1)
        else $error("single-ended channel pin set wrong");
    a_dc_pins: assert property (@(posedge clk) disable iff (!rst_n)
        scan_sel_ff[`CDS_POS_CH_B_SCAN] && ch_b_coupling != `CDS_COUP_AC && ch_b_input_config == `CDS_INSRC_DIFF
        |=> mask_ff[3:2] == 2'h3)
        else $error("DC-coupled channel pins skipped");
    a_valid_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        !scan_step |=> !valid_ff)
        else $error("scan result without step");
    a_pin_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !scan_step |=> $stable(scan_pin))
        else $error("scan pin moved without step");
endmodule

/* verification/test_cds_cal_scan_cfg.sv */
`include "cds_defines.svh"
`define CHECK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module test_cds_cal_scan_cfg
    import cds_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, reg_wr, reg_rd, scan_step, mod_tick;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, thr;
    logic [1:0] a_cfg, b_cfg, scan_pin;
    logic a_coup, b_coup, scan_pin_valid;
    logic [15:0] s_in, s_out;
    logic [3:0] g_code, mask;
    logic signed [4:0] g_tenth;
    int errors = 0;
    int samples_checked = 0;
    cds_byte_t rd;
    logic [7:0] sel;
    logic [1:0] pins [3] = '{2'h2, 2'h3, 2'h2};
    cds_cal_scan_cfg #(.SAMPLE_W(16)) i_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ch_a_input_config(a_cfg),
        .ch_a_coupling(a_coup), .ch_b_input_config(b_cfg), .ch_b_coupling(b_coup), .scan_step(scan_step),
        .mod_tick(mod_tick), .ch_b_sample_in(s_in), .ch_b_sample_out(s_out), .ch_b_gain_trim(g_code),
        .ch_b_gain_trim_tenth_db(g_tenth), .scan_pin_mask(mask), .scan_pin_valid(scan_pin_valid),
        .scan_pin(scan_pin), .diag_threshold_reg_a(thr));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, output cds_byte_t d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic step();
        @(posedge clk);
        scan_step <= 1'b1;
        @(posedge clk);
        scan_step <= 1'b0;
        #1;
    endtask
    task automatic chans(input logic [3:0] c);
        @(posedge clk);
        a_cfg <= {1'b0, c[0]};
        a_coup <= c[1];
        b_cfg <= {1'b0, c[2]};
        b_coup <= c[3];
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic delay_run(input logic [7:0] n, input int cnt);
        wr(`CDS_OFF_PHASE_TRIM, n);
        for (int k = 0; k < cnt; k++) begin
            @(posedge clk);
            mod_tick <= 1'b1;
            s_in <= 16'(k + 1);
            @(posedge clk);
            mod_tick <= 1'b0;
            #1;
            if (k >= n) `CHECK(s_out, 16'(k + 1 - n))
        end
    endtask
    function automatic logic [3:0] exp_mask(input logic [7:0] s, input logic [3:0] c);
        logic a_on, b_on;
        a_on = s[7] & (c[1] | s[0]);
        b_on = s[6] & (c[3] | s[0]);
        return {b_on & (~c[2] | s[1]), b_on, a_on & (~c[0] | s[1]), a_on};
    endfunction
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, reg_wr, reg_rd, scan_step, mod_tick, a_coup, b_coup} = '0;
        {reg_addr, reg_wdata, a_cfg, b_cfg, s_in} = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        `CHECK(g_code, 4'h8)
        `CHECK(g_tenth, 5'sh0)
        rdr(`CDS_OFF_GAIN_TRIM, rd); `CHECK(rd, 8'h80)
        rdr(`CDS_OFF_PHASE_TRIM, rd); `CHECK(rd, 8'h00)
        rdr(`CDS_OFF_SCAN_SEL, rd); `CHECK(rd, 8'h00)
        `CHECK(thr, `CDS_RST_THRESH_A)
        rdr(`CDS_OFF_THRESH_A, rd); `CHECK(rd, `CDS_RST_THRESH_A)
        wr(`CDS_OFF_THRESH_A, 8'h5a);
        rdr(`CDS_OFF_THRESH_A, rd); `CHECK(rd, 8'h5a)
        `CHECK(thr, 8'h5a)
        rdr(8'h00, rd); `CHECK(rd, 8'h00)
        wr(`CDS_OFF_SCAN_SEL, 8'hc0);
        chans(4'h8);
        `CHECK(mask, 4'hc)
        for (int i = 0; i < 3; i++) begin
            step(); `CHECK({scan_pin_valid, scan_pin}, {1'b1, pins[i]})
        end
        wr(`CDS_OFF_SCAN_SEL, 8'h00);
        chans(4'hf);
        step(); `CHECK(scan_pin_valid, 1'b0)
        for (int s = 0; s < 16; s++) begin
            sel = {s[3], s[2], 4'h0, s[1], s[0]};
            wr(`CDS_OFF_SCAN_SEL, sel);
            for (int c = 0; c < 16; c++) begin
                chans(4'(c)); `CHECK(mask, exp_mask(sel, 4'(c)))
            end
        end
        for (int g = 0; g < 16; g += 5) begin
            wr(`CDS_OFF_GAIN_TRIM, {4'(g), 4'h0});
            repeat (2) @(posedge clk);
            #1;
            `CHECK(g_code, 4'(g))
            `CHECK(g_tenth, 5'(g - 8))
            rdr(`CDS_OFF_GAIN_TRIM, rd); `CHECK(rd, {4'(g), 4'h0})
        end
        delay_run(8'h00, 4);
        delay_run(8'h01, 4);
        delay_run(8'h03, 10);
        delay_run(8'hff, 260);
        rdr(`CDS_OFF_PHASE_TRIM, rd); `CHECK(rd, 8'hff)
        results();
    end
    initial begin
        #1000000;
        errors++;
        results();
    end
endmodule
